// [design/tws_device.sv]
module tws_device
  import tws_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  tws_if.slave                  bus,
  input  wire logic             addr_sel_i,
  input  wire logic             autoselect_success_flag_i,
  input  wire logic             autoselect_idle_flag_i,
  input  wire logic             pll_lock_flag_i,
  input  wire logic [4:0]       vco_band_readback_i,
  input  wire logic [2:0]       tune_level_i,
  output logic [NUM_CFG*8-1:0]  cfg_regs_o,
  output logic                  fast_lock_enable_o,
  output logic                  por_flag_o
);
  // ==========================================
  // line conditioning
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic asel_meta;
  logic asel;

  // both lines see the same delay, so start/stop ordering survives
  tws_line_filter u_scl_filt (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .line_i  (bus.scl),
    .level_o (scl_f)
  );
  tws_line_filter u_sda_filt (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .line_i  (bus.sda),
    .level_o (sda_f)
  );

  // previous levels for edge finding; select pin is a strap, synced too
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      asel_meta <= 1'b0;
      asel      <= 1'b0;
    end else begin
      scl_q     <= scl_f;
      sda_q     <= sda_f;
      asel_meta <= addr_sel_i;
      asel      <= asel_meta;
    end
  end

  // ==========================================
  // bus events
  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  // data moving under a high clock is never data
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;

  // ==========================================
  // state
  tws_dstate_t state;
  logic [3:0]  cnt;
  logic        ack_ph;
  logic [7:0]  sh;
  logic [7:0]  ptr;
  logic        rw;
  logic        mack;
  logic        sda_oe;
  logic        por;
  logic        por_rd;
  logic [7:0]  cfg [NUM_CFG];

  // ==========================================
  // decode
  wire [6:0] dev_addr   = DEV_ADDR_BASE | {6'h00, asel};
  wire       addr_match = (sh[7:1] == dev_addr);
  wire       wr_ok      = (ptr < 8'(NUM_CFG));
  wire       byte_done  = (cnt == 4'h8) && !ack_ph;
  wire [7:0] stat1      = {por, autoselect_success_flag_i,
                           autoselect_idle_flag_i,
                           pll_lock_flag_i, 4'h0};
  wire [7:0] stat2      = {vco_band_readback_i, tune_level_i};
  wire [7:0] rd_byte    = (ptr == STAT1_IDX) ? stat1 :
                          (ptr == STAT2_IDX) ? stat2 :
                          wr_ok ? cfg[ptr[3:0]] : 8'h00;
  wire       rd_stat1   = (ptr == STAT1_IDX);

  // ==========================================
  // protocol engine
  // start wins over every bus event other than reset and may arrive mid-byte (repeated start)
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state  <= D_IDLE;
      cnt    <= 4'h0;
      ack_ph <= 1'b0;
      sh     <= 8'h00;
      ptr    <= 8'h00;
      rw     <= 1'b0;
      mack   <= 1'b0;
      sda_oe <= 1'b0;
      por    <= POR_RESET;
      por_rd <= 1'b0;
    end else if (start_det) begin
      state  <= D_ADDR;
      cnt    <= 4'h0;
      ack_ph <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state  <= D_IDLE;
      ack_ph <= 1'b0;
      sda_oe <= 1'b0;
      por_rd <= 1'b0;
      if (por_rd) por <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        D_ADDR, D_PTR, D_WDATA: begin
          if (!ack_ph && cnt != 4'h8) begin
            sh  <= {sh[6:0], sda_f};
            cnt <= cnt + 4'h1;
          end
        end
        D_RDATA: cnt <= cnt + 4'h1;
        D_RACK:  mack <= ~sda_f;
        D_IDLE:  ;
        default: state <= D_IDLE;
      endcase
    end else if (scl_fall) begin
      unique case (state)
        D_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              sda_oe <= 1'b1;
              ack_ph <= 1'b1;
              rw     <= sh[0];
            end else begin
              state <= D_IDLE;      // not ours: wait for next start
            end
          end else if (ack_ph) begin
            ack_ph <= 1'b0;
            cnt    <= 4'h0;
            if (rw) begin
              state  <= D_RDATA;
              sh     <= rd_byte;
              sda_oe <= ~rd_byte[7];
              ptr    <= ptr + 8'h01;
              por_rd <= por_rd | rd_stat1;
            end else begin
              state  <= D_PTR;
              sda_oe <= 1'b0;
            end
          end
        end
        D_PTR: begin
          if (byte_done) begin
            ptr    <= sh;
            sda_oe <= 1'b1;
            ack_ph <= 1'b1;
          end else if (ack_ph) begin
            ack_ph <= 1'b0;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
            state  <= D_WDATA;
          end
        end
        D_WDATA: begin
          if (byte_done) begin
            // status and unmapped bytes are refused with a nack
            sda_oe <= wr_ok;
            ack_ph <= 1'b1;
            ptr    <= ptr + 8'h01;
          end else if (ack_ph) begin
            ack_ph <= 1'b0;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
          end
        end
        D_RDATA: begin
          if (cnt == 4'h8) begin
            sda_oe <= 1'b0;         // free the line for the master ack
            state  <= D_RACK;
          end else begin
            sh     <= {sh[6:0], 1'b0};
            sda_oe <= ~sh[6];
          end
        end
        D_RACK: begin
          cnt <= 4'h0;
          if (mack) begin
            state  <= D_RDATA;
            sh     <= rd_byte;
            sda_oe <= ~rd_byte[7];
            ptr    <= ptr + 8'h01;
            por_rd <= por_rd | rd_stat1;
          end else begin
            state <= D_IDLE;
          end
        end
        D_IDLE:  ;
        default: state <= D_IDLE;
      endcase
    end
  end

  // ==========================================
  // configuration storage
  // written on the eighth falling edge, same edge that raises the ack
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_CFG; i++) cfg[i] <= CFG_RESET;
    end else if (scl_fall && state == D_WDATA && byte_done && wr_ok) begin
      cfg[ptr[3:0]] <= sh;
    end
  end

  // ==========================================
  // outputs
  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : g_cfg
      assign cfg_regs_o[g*8 +: 8] = cfg[g];
    end
  endgenerate
  // lock reading is only trustworthy once software sets this
  assign fast_lock_enable_o = cfg[TEST_REG_IDX[3:0]][FASTLOCK_BIT];
  assign por_flag_o         = por;
  assign bus.s_sda_out      = 1'b0;   // open drain: only ever pulls low
  assign bus.s_sda_oe       = sda_oe;
endmodule

// [design/tws_host.sv]
// ==========================================
// bus master with an Avalon-MM command port
module tws_host
  import tws_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  tws_if.master            bus,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);
  logic        sda_f;
  logic [4:0]  qdiv;
  logic        tick;
  tws_hstate_t state;
  logic [1:0]  ph;
  logic [3:0]  bitn;
  logic        nack;
  logic [7:0]  rdata;
  logic        scl_oe;
  logic        sda_oe;
  logic [7:0]  ptr;
  logic [7:0]  wdata;
  logic        rd;
  logic        asel;

  tws_line_filter u_sda_filt (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .line_i  (bus.sda),
    .level_o (sda_f)
  );

  // ==========================================
  // register port decode
  wire        wr_acc = avs_write_i & ~avs_waitrequest_o;
  wire        busy   = (state != H_IDLE);
  wire        go     = wr_acc && avs_address_i == REG_CTRL && avs_writedata_i[CTRL_GO_BIT] && !busy;
  wire [31:0] rd_mux = (avs_address_i == REG_CTRL)   ? {29'h0, asel, rd, 1'b0} :
                       (avs_address_i == REG_PTR)    ? {24'h0, ptr} :
                       (avs_address_i == REG_WDATA)  ? {24'h0, wdata} :
                       (avs_address_i == REG_STATUS) ? {16'h0, rdata, 6'h00, nack, busy} :
                       32'h0;

  // one wait cycle per access; settings frozen while a transfer runs
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      ptr               <= 8'h00;
      wdata             <= 8'h00;
      rd                <= 1'b0;
      asel              <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o) avs_readdata_o <= rd_mux;
      if (wr_acc && !busy && avs_address_i == REG_PTR) ptr <= avs_writedata_i[7:0];
      if (wr_acc && !busy && avs_address_i == REG_WDATA) wdata <= avs_writedata_i[7:0];
      if (wr_acc && !busy && avs_address_i == REG_CTRL) begin
        rd   <= avs_writedata_i[CTRL_RD_BIT];
        asel <= avs_writedata_i[CTRL_ASEL_BIT];
      end
    end
  end

  // ==========================================
  // quarter-bit divider: sets the bus clock to about 390 kHz, under the 400 kHz ceiling
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      qdiv <= 5'h00;
      tick <= 1'b0;
    end else begin
      tick <= (qdiv == 5'(SCL_QTR_CYC - 1));
      qdiv <= (qdiv == 5'(SCL_QTR_CYC - 1)) ? 5'h00 : qdiv + 5'h01;
    end
  end

  // ==========================================
  // byte sequencer
  wire [6:0] addr    = DEV_ADDR_BASE | {6'h00, asel};
  wire [7:0] tx_byte = (state == H_ADDRW) ? {addr, 1'b0} :
                       (state == H_PTR)   ? ptr :
                       (state == H_WDATA) ? wdata : {addr, 1'b1};
  wire       tx_bit  = tx_byte[~bitn[2:0]];
  wire       last    = (bitn == 4'h8);

  // each symbol is four quarters: set data, raise clock, sample, lower clock
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state  <= H_IDLE;
      ph     <= 2'h0;
      bitn   <= 4'h0;
      nack   <= 1'b0;
      rdata  <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (go) begin
      state <= H_START;
      ph    <= 2'h0;
      bitn  <= 4'h0;
      nack  <= 1'b0;
    end else if (tick && busy) begin
      ph <= ph + 2'h1;
      unique case (state)
        H_START: begin
          if (ph == 2'h1) sda_oe <= 1'b1;
          if (ph == 2'h3) begin
            scl_oe <= 1'b1;
            state  <= H_ADDRW;
          end
        end
        H_ADDRW, H_PTR, H_WDATA, H_ADDRR: begin
          if (ph == 2'h0) sda_oe <= last ? 1'b0 : ~tx_bit;
          if (ph == 2'h1) scl_oe <= 1'b0;
          if (ph == 2'h2 && last) nack <= sda_f;
          if (ph == 2'h3) begin
            scl_oe <= 1'b1;
            bitn   <= last ? 4'h0 : bitn + 4'h1;
            if (last) begin
              // a refused byte ends the transfer; software retries
              if (nack) state <= H_STOP;
              else if (state == H_ADDRW) state <= H_PTR;
              else if (state == H_PTR) state <= rd ? H_RSTART : H_WDATA;
              else if (state == H_WDATA) state <= H_STOP;
              else state <= H_RDATA;
            end
          end
        end
        H_RSTART: begin
          if (ph == 2'h0) sda_oe <= 1'b0;
          if (ph == 2'h1) scl_oe <= 1'b0;
          if (ph == 2'h2) sda_oe <= 1'b1;
          if (ph == 2'h3) begin
            scl_oe <= 1'b1;
            state  <= H_ADDRR;
          end
        end
        H_RDATA: begin
          // single byte read: ninth bit left high as the closing nack
          if (ph == 2'h0) sda_oe <= 1'b0;
          if (ph == 2'h1) scl_oe <= 1'b0;
          if (ph == 2'h2 && !last) rdata <= {rdata[6:0], sda_f};
          if (ph == 2'h3) begin
            scl_oe <= 1'b1;
            bitn   <= last ? 4'h0 : bitn + 4'h1;
            if (last) state <= H_STOP;
          end
        end
        H_STOP: begin
          if (ph == 2'h0) sda_oe <= 1'b1;
          if (ph == 2'h1) scl_oe <= 1'b0;
          if (ph == 2'h2) sda_oe <= 1'b0;
          if (ph == 2'h3) state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign bus.m_scl_out = 1'b0;
  assign bus.m_scl_oe  = scl_oe;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe  = sda_oe;
endmodule

// [design/tws_line_filter.sv]
// ==========================================
// two-flop synchroniser plus majority-free glitch filter
module tws_line_filter
  import tws_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic line_i,
  output logic      level_o
);
  logic                meta;
  logic                sync;
  logic [FILT_LEN-1:0] hist;
  wire                 all_hi = &hist;
  wire                 all_lo = ~|hist;
  // level only moves once every sample agrees, so spikes die here
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta    <= 1'b1;
      sync    <= 1'b1;
      hist    <= '1;
      level_o <= 1'b1;
    end else begin
      meta <= line_i;
      sync <= meta;
      hist <= {hist[FILT_LEN-2:0], sync};
      if (all_hi) level_o <= 1'b1;
      else if (all_lo) level_o <= 1'b0;
    end
  end
endmodule

// [dv/tb.sv]
// ==========================================
// host and device joined; software side drives the host
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tws_pkg::*;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] rdq;
  logic        addr_sel, asel_ok, asel_idle, lock;
  logic [4:0]  band;
  logic [2:0]  tune;
  wire  [31:0] av_rdata;
  wire         av_wait, fast_lock, por_flag;
  wire  [95:0] cfg_regs;
  int          n_errors = 0;
  int          checks = 0;
  tws_if bus_if ();
  tws_host tws_host_inst (.mclk_i, .nrst_i, .bus(bus_if.master), .avs_address_i(av_addr), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait));
  tws_device tws_device_inst (.mclk_i, .nrst_i, .bus(bus_if.slave), .addr_sel_i(addr_sel),
    .autoselect_success_flag_i(asel_ok), .autoselect_idle_flag_i(asel_idle), .pll_lock_flag_i(lock),
    .vco_band_readback_i(band), .tune_level_i(tune), .cfg_regs_o(cfg_regs), .fast_lock_enable_o(fast_lock),
    .por_flag_o(por_flag));
  tws_checker tws_checker_inst (.mclk_i, .nrst_i, .m_scl_out(bus_if.m_scl_out), .m_scl_oe(bus_if.m_scl_oe),
    .m_sda_out(bus_if.m_sda_out), .m_sda_oe(bus_if.m_sda_oe), .s_sda_out(bus_if.s_sda_out),
    .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  always #20 mclk_i = ~mclk_i;
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one Avalon access; held until waitrequest is sampled low
  task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
    av_addr  <= a;
    av_rd    <= rd;
    av_wr    <= !rd;
    av_wdata <= d;
    do @(posedge mclk_i); while (av_wait !== 1'b0);
    rdq = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  // one host transfer; busy must be seen set before its clearing counts
  task automatic xfer(input logic rd, input logic asel, input logic [7:0] ptr, input logic [7:0] wd);
    logic sb;
    int   n;
    sb = 1'b0;
    n = 0;
    av(1'b0, REG_PTR, {24'h0, ptr});
    av(1'b0, REG_WDATA, {24'h0, wd});
    av(1'b0, REG_CTRL, {29'h0, asel, rd, 1'b1});
    do begin
      av(1'b1, REG_STATUS, 32'h0);
      sb |= rdq[STAT_BUSY_BIT];
      n++;
    end while (!(sb && rdq[STAT_BUSY_BIT] === 1'b0) && n < 4000);
    // a poll limit that runs out is a hang and counts as a mismatch
    chk("transfer finished", {31'h0, sb && rdq[STAT_BUSY_BIT] === 1'b0}, 32'h1);
  endtask
  // ==========================================
  // scenarios
  task t_status;
    chk("por after reset", por_flag, 1);
    xfer(1'b0, 1'b0, TEST_REG_IDX, 8'h08);
    chk("fast lock enable", fast_lock, 1);
    asel_ok   <= 1'b1;
    asel_idle <= 1'b0;
    lock      <= 1'b1;
    xfer(1'b1, 1'b0, STAT1_IDX, 8'h00);
    chk("status1 busy autoselect", rdq[15:8], 8'hD0);
    chk("por cleared by read", por_flag, 0);
    asel_ok   <= 1'b0;
    asel_idle <= 1'b1;
    lock      <= 1'b0;
    xfer(1'b1, 1'b0, STAT1_IDX, 8'h00);
    chk("status1 idle", rdq[15:8], 8'h20);
    // every tune code once, band varied alongside
    for (int i = 0; i < 8; i++) begin
      band <= 5'(i * 3 + 1);
      tune <= 3'(i);
      xfer(1'b1, 1'b0, STAT2_IDX, 8'h00);
      chk("status2", rdq[15:8], {5'(i * 3 + 1), 3'(i)});
    end
    $display("test status done");
  endtask
  task t_write_read;
    xfer(1'b0, 1'b0, 8'h03, 8'hA5);
    chk("write ack", rdq[STAT_NACK_BIT], 0);
    chk("cfg reg3", cfg_regs[31:24], 8'hA5);
    xfer(1'b1, 1'b0, 8'h03, 8'h00);
    chk("read ack", rdq[STAT_NACK_BIT], 0);
    chk("read reg3", rdq[15:8], 8'hA5);
    $display("test write_read done");
  endtask
  task t_address;
    av(1'b1, 4'h2, 32'h0);
    chk("unmapped read", rdq, 32'h0);
    xfer(1'b0, 1'b1, 8'h01, 8'h3C);
    chk("foreign address nack", rdq[STAT_NACK_BIT], 1);
    chk("cfg reg1 untouched", cfg_regs[15:8], 8'h00);
    addr_sel <= 1'b1;
    xfer(1'b0, 1'b1, 8'h01, 8'h3C);
    chk("alt address ack", rdq[STAT_NACK_BIT], 0);
    chk("cfg reg1", cfg_regs[15:8], 8'h3C);
    xfer(1'b1, 1'b1, 8'h01, 8'h00);
    chk("alt address read", rdq[15:8], 8'h3C);
    addr_sel <= 1'b0;
    xfer(1'b0, 1'b0, STAT1_IDX, 8'hFF);
    chk("status write refused", rdq[STAT_NACK_BIT], 1);
    xfer(1'b0, 1'b0, 8'h05, 8'h77);
    chk("retry after nack", cfg_regs[47:40], 8'h77);
    $display("test address done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    av_addr   = 4'h0;
    av_rd     = 1'b0;
    av_wr     = 1'b0;
    av_wdata  = 32'h0;
    addr_sel  = 1'b0;
    asel_ok   = 1'b0;
    asel_idle = 1'b1;
    lock      = 1'b0;
    band      = 5'h00;
    tune      = 3'h0;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    // device filters need a quiet spell after reset
    repeat (10) @(posedge mclk_i);
    t_status;
    t_write_read;
    t_address;
    print_verdict;
  end
  // about twice the expected run length
  initial begin
    #(90000 * 40);
    n_errors++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule

// [dv/tws_checker.sv]
// ==========================================
// protocol checker on the joined two-wire bus
module tws_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] rises;
  // raw-line conditions; no filter here, so a glitch would show up as a fault
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire stop_ev  = scl && scl_q && !sda_q && sda;
  wire scl_rise = scl && !scl_q;
  // clock pulses since the last start or stop
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rises <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rises <= (start_ev || stop_ev) ? 8'h00 : rises + {7'h00, scl_rise};
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // sequences
  sequence s_low_run;
    !scl [*8];
  endsequence
  sequence s_high_run;
    scl [*8];
  endsequence
  sequence s_idle_run;
    (scl && sda) [*8];
  endsequence
  // ==========================================
  // assertions
  AST_RESET_RELEASE: assert property (disable iff (1'b0) !nrst_i |=> !m_scl_oe && !m_sda_oe && !s_sda_oe)
    else $error("bus not released in reset");
  AST_FRAME_NINE: assert property ((start_ev || stop_ev) |-> (rises == 8'h00 || (rises % 8'h09) == 8'h01))
    else $error("byte frame not nine clocks");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> s_low_run)
    else $error("clock low phase too short");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> s_high_run)
    else $error("clock high phase too short");
  AST_START_THEN_CLOCK: assert property (start_ev |-> ##[1:40] !scl)
    else $error("start not followed by clock");
  AST_STOP_IDLE: assert property (stop_ev |-> s_idle_run)
    else $error("bus not idle after stop");
  AST_DEV_SDA_SCL_LOW: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("device moved data with clock high");
  AST_HOST_SDA_CTRL: assert property ($changed(m_sda_oe) && scl && !s_sda_oe |-> start_ev || stop_ev)
    else $error("host data change with clock high is not start or stop");
  AST_DEV_ACK_HOLD: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*8])
    else $error("device released data in clock high");
  AST_DRIVE_LOW: assert property (m_scl_oe |-> !scl && !m_scl_out)
    else $error("clock drive not open drain");
  AST_SDA_WIRED: assert property ((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out) |-> !sda)
    else $error("data line not pulled low");
endmodule

// [include/tws_if.sv]
// ==========================================
// two-wire bus with open-drain resolution
interface tws_if;
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // pull-ups keep both lines high unless someone drives
  assign scl = m_scl_oe ? m_scl_out : 1'b1;
  assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (s_sda_oe ? s_sda_out : 1'b1);
  modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_out, s_sda_oe, input scl, sda);
endinterface

// [include/tws_pkg.sv]
package tws_pkg;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS     = 40;
  localparam int SCL_MIN_PERIOD_NS = 2500;  // 400 kHz ceiling
  // quarter of the fastest bus period, rounded up
  localparam int SCL_QTR_CYC = (SCL_MIN_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_LEN    = 3;           // glitch filter samples
  // ==========================================
  // device address and register map
  localparam logic [6:0] DEV_ADDR_BASE = 7'h60;
  localparam int         NUM_CFG       = 12;
  localparam logic [7:0] TEST_REG_IDX  = 8'h0B;
  localparam logic [7:0] STAT1_IDX     = 8'h0C;
  localparam logic [7:0] STAT2_IDX     = 8'h0D;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic       POR_RESET     = 1'b1;
  localparam int FASTLOCK_BIT = 3;
  localparam int POR_BIT      = 7;
  localparam int ASEL_OK_BIT  = 6;
  localparam int ASEL_IDL_BIT = 5;
  localparam int LOCK_BIT     = 4;
  localparam int BAND_LSB     = 3;
  // ==========================================
  // controller registers (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_PTR    = 4'h4;
  localparam logic [3:0] REG_WDATA  = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_RD_BIT    = 1;
  localparam int CTRL_ASEL_BIT  = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;
  localparam int STAT_RDATA_LSB = 8;
  // ==========================================
  // state machines
  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_ADDR  = 3'b001,
    D_PTR   = 3'b010,
    D_WDATA = 3'b011,
    D_RDATA = 3'b100,
    D_RACK  = 3'b101
  } tws_dstate_t;
  typedef enum logic [3:0] {
    H_IDLE   = 4'b0000,
    H_START  = 4'b0001,
    H_ADDRW  = 4'b0010,
    H_PTR    = 4'b0011,
    H_WDATA  = 4'b0100,
    H_RSTART = 4'b0101,
    H_ADDRR  = 4'b0110,
    H_RDATA  = 4'b0111,
    H_STOP   = 4'b1000
  } tws_hstate_t;
endpackage
